// ===== hw/dcb_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts for DC braking control
// Assumes: Byte addresses on a 32-bit classic Wishbone bus
// Notes: Frequencies in 0.01 Hz units, times in 0.1 s units
`ifndef DCB_CFG_SVH
`define DCB_CFG_SVH

`define DCB_ADR_CTRL 8'h00
`define DCB_ADR_THRESH 8'h04
`define DCB_ADR_DELAY 8'h08
`define DCB_ADR_LEVEL 8'h0C
`define DCB_ADR_ACTIVE 8'h10
`define DCB_ADR_TERM 8'h14
`define DCB_ADR_STATUS 8'h18

`define DCB_CTRL_SRC_LSB 0
`define DCB_CTRL_LEVEL_BIT 2
`define DCB_CTRL_LIGHT_BIT 3

`define DCB_SRC_OFF 2'h0
`define DCB_SRC_STOP 2'h1
`define DCB_SRC_FREQ 2'h2

`define DCB_THRESH_MAX 16'h1770
`define DCB_RELEASE_HYST 17'h000C8
`define DCB_DELAY_MAX 10'h032
`define DCB_ACTIVE_MAX 10'h258
`define DCB_LEVEL_MAX_NORMAL 7'h64
`define DCB_LEVEL_MAX_LIGHT 7'h46

`define DCB_RST_THRESH 16'h0032
`define DCB_RST_ACTIVE 10'h005
`define DCB_RST_LEVEL 7'h32

`define DCB_TICK_NS 100000000
`define DCB_CLK_PERIOD_NS 4

`endif

// ===== hw/dcb_pkg.sv
// Purpose: Types shared by the DC braking control block
// Assumes: Used together with dcb_cfg.svh
// Notes: Frequencies are unsigned 0.01 Hz counts
package dcb_pkg;

	typedef enum logic [1:0]
	{
		DCB_IDLE = 2'h0,
		DCB_FREERUN = 2'h1,
		DCB_BRAKE = 2'h3,
		DCB_DONE = 2'h2
	} dcb_state_t;

	typedef struct packed
	{
		logic run_cmd;
		logic [15:0] freq_cmd;
		logic [15:0] out_freq;
		logic [6:0] terminals;
	} dcb_motor_t;

	typedef struct packed
	{
		logic shutoff;
		logic brake_on;
		logic [6:0] current_pct;
	} dcb_drive_t;

endpackage

// ===== hw/dcb_brake_ctrl.sv
// Purpose: DC injection braking at stop, with Wishbone register access
// Assumes: Motor status inputs synchronous to ref_clk
// Notes: shutoff marks the free-run gap and braking; idle leaves normal control alone
`timescale 1ns/1ps
`include "dcb_cfg.svh"

module dcb_brake_ctrl
#(
	parameter int TICK_CYCLES = `DCB_TICK_NS / `DCB_CLK_PERIOD_NS
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Motor side
	input wire dcb_pkg::dcb_motor_t motor_in,
	output dcb_pkg::dcb_drive_t drive_out
);
	import dcb_pkg::*;

	logic [1:0] brake_source_select_reg, brake_source_select_next;
	logic brake_edge_level_select_reg, brake_edge_level_select_next;
	logic light_duty_rating_reg, light_duty_rating_next;
	logic [15:0] brake_freq_threshold_reg, brake_freq_threshold_next;
	logic [9:0] brake_freerun_delay_reg, brake_freerun_delay_next;
	logic [6:0] brake_current_level_reg, brake_current_level_next;
	logic [9:0] brake_active_time_reg, brake_active_time_next;
	logic [2:0] term_assign_reg, term_assign_next;
	logic [31:0] dat_reg, dat_next;
	logic ack_reg, ack_next;
	dcb_state_t state_reg, state_next;
	logic [31:0] pre_reg, pre_next;
	logic [9:0] time_reg, time_next;
	logic stop_latch_reg, stop_latch_next;
	logic freq_latch_reg, freq_latch_next;
	logic trig_prev_reg, trig_prev_next;
	dcb_drive_t drive_reg, drive_next;

	logic external_brake_input;
	logic trigger;
	logic tick;
	logic [16:0] release_level;
	logic [6:0] level_cap;
	logic wr;

	always_comb
	begin
		// Terminal index 0 means no input carries the braking function
		external_brake_input = 1'b0;
		if (term_assign_reg != 3'h0)
			external_brake_input = motor_in.terminals[term_assign_reg - 3'h1];
		release_level = {1'b0, brake_freq_threshold_reg} + `DCB_RELEASE_HYST;
		tick = (pre_reg == 32'(TICK_CYCLES - 1));
		level_cap = light_duty_rating_reg ? `DCB_LEVEL_MAX_LIGHT : `DCB_LEVEL_MAX_NORMAL;
		wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg && wb_sel_i[0];
		// Worked out first so the status read and the sequencer see this cycle's value
		trigger = stop_latch_reg || freq_latch_reg ||
			(external_brake_input && brake_source_select_reg != `DCB_SRC_FREQ);
		trig_prev_next = trigger;

		brake_source_select_next = brake_source_select_reg;
		brake_edge_level_select_next = brake_edge_level_select_reg;
		light_duty_rating_next = light_duty_rating_reg;
		brake_freq_threshold_next = brake_freq_threshold_reg;
		brake_freerun_delay_next = brake_freerun_delay_reg;
		brake_current_level_next = brake_current_level_reg;
		brake_active_time_next = brake_active_time_reg;
		term_assign_next = term_assign_reg;
		ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
		dat_next = 32'h00000000;

		// Writes clamp to the setting maxima, the level always to the normal-duty one; a source code of 3 is dropped
		if (wr)
		begin
			case (wb_adr_i)
				`DCB_ADR_CTRL:
				begin
					if (wb_dat_i[`DCB_CTRL_SRC_LSB +: 2] != 2'h3)
						brake_source_select_next = wb_dat_i[`DCB_CTRL_SRC_LSB +: 2];
					brake_edge_level_select_next = wb_dat_i[`DCB_CTRL_LEVEL_BIT];
					light_duty_rating_next = wb_dat_i[`DCB_CTRL_LIGHT_BIT];
				end
				`DCB_ADR_THRESH:
					brake_freq_threshold_next = (wb_dat_i[15:0] > `DCB_THRESH_MAX) ?
						`DCB_THRESH_MAX : wb_dat_i[15:0];
				`DCB_ADR_DELAY:
					brake_freerun_delay_next = (wb_dat_i[9:0] > `DCB_DELAY_MAX) ?
						`DCB_DELAY_MAX : wb_dat_i[9:0];
				`DCB_ADR_LEVEL:
					brake_current_level_next = (wb_dat_i[6:0] > `DCB_LEVEL_MAX_NORMAL) ?
						`DCB_LEVEL_MAX_NORMAL : wb_dat_i[6:0];
				`DCB_ADR_ACTIVE:
					brake_active_time_next = (wb_dat_i[9:0] > `DCB_ACTIVE_MAX) ?
						`DCB_ACTIVE_MAX : wb_dat_i[9:0];
				`DCB_ADR_TERM:
					term_assign_next = wb_dat_i[2:0];
				default:
					term_assign_next = term_assign_reg;
			endcase
		end
		if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg)
		begin
			case (wb_adr_i)
				`DCB_ADR_CTRL:
					dat_next = {28'h0000000, light_duty_rating_reg,
						brake_edge_level_select_reg, brake_source_select_reg};
				`DCB_ADR_THRESH:
					dat_next = {16'h0000, brake_freq_threshold_reg};
				`DCB_ADR_DELAY:
					dat_next = {22'h000000, brake_freerun_delay_reg};
				`DCB_ADR_LEVEL:
					dat_next = {25'h0000000, brake_current_level_reg};
				`DCB_ADR_ACTIVE:
					dat_next = {22'h000000, brake_active_time_reg};
				`DCB_ADR_TERM:
					dat_next = {29'h00000000, term_assign_reg};
				`DCB_ADR_STATUS:
					dat_next = {16'h0000, time_reg, trigger, freq_latch_reg,
						stop_latch_reg, external_brake_input, state_reg};
				default:
					dat_next = 32'h00000000;
			endcase
		end

		// At-stop latch holds until run returns, so level mode keeps braking
		stop_latch_next = stop_latch_reg;
		if (brake_source_select_reg != `DCB_SRC_STOP || motor_in.run_cmd)
			stop_latch_next = 1'b0;
		else if (motor_in.out_freq < brake_freq_threshold_reg)
			stop_latch_next = 1'b1;
		// Hysteresis stops chatter around the threshold
		freq_latch_next = freq_latch_reg;
		if (brake_source_select_reg != `DCB_SRC_FREQ)
			freq_latch_next = 1'b0;
		else if ({1'b0, motor_in.freq_cmd} >= release_level)
			freq_latch_next = 1'b0;
		else if (motor_in.freq_cmd <= brake_freq_threshold_reg &&
			motor_in.out_freq <= brake_freq_threshold_reg)
			freq_latch_next = 1'b1;

		pre_next = tick ? 32'h00000000 : pre_reg + 32'h00000001;
		state_next = state_reg;
		time_next = time_reg;
		case (state_reg)
			DCB_IDLE:
			begin
				pre_next = 32'h00000000;
				time_next = 10'h000;
				if (trigger && !trig_prev_reg)
					state_next = DCB_FREERUN;
			end
			DCB_FREERUN:
			begin
				if (time_reg >= brake_freerun_delay_reg)
				begin
					state_next = DCB_BRAKE;
					time_next = 10'h000;
					pre_next = 32'h00000000;
				end
				else if (tick)
					time_next = time_reg + 10'h001;
			end
			DCB_BRAKE:
			begin
				if (!brake_edge_level_select_reg && time_reg >= brake_active_time_reg)
					state_next = DCB_DONE;
				else if (tick)
					time_next = time_reg + 10'h001;
			end
			DCB_DONE:
			begin
				if (!trigger)
					state_next = DCB_IDLE;
			end
			default:
				state_next = DCB_IDLE;
		endcase
		// Level mode follows the trigger and ignores the active time
		if (brake_edge_level_select_reg && !trigger && state_reg != DCB_IDLE)
			state_next = DCB_IDLE;
		if (brake_edge_level_select_reg && trigger && state_reg == DCB_DONE)
			state_next = DCB_BRAKE;

		drive_next.shutoff = (state_next == DCB_FREERUN) || (state_next == DCB_BRAKE);
		drive_next.brake_on = (state_next == DCB_BRAKE);
		drive_next.current_pct = 7'h00;
		if (state_next == DCB_BRAKE)
			drive_next.current_pct = (brake_current_level_reg > level_cap) ?
				level_cap : brake_current_level_reg;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			brake_source_select_reg <= `DCB_SRC_OFF;
			brake_edge_level_select_reg <= 1'b0;
			light_duty_rating_reg <= 1'b0;
			brake_freq_threshold_reg <= `DCB_RST_THRESH;
			brake_freerun_delay_reg <= 10'h000;
			brake_current_level_reg <= `DCB_RST_LEVEL;
			brake_active_time_reg <= `DCB_RST_ACTIVE;
			term_assign_reg <= 3'h0;
			dat_reg <= 32'h00000000;
			ack_reg <= 1'b0;
			state_reg <= DCB_IDLE;
			pre_reg <= 32'h00000000;
			time_reg <= 10'h000;
			stop_latch_reg <= 1'b0;
			freq_latch_reg <= 1'b0;
			trig_prev_reg <= 1'b0;
			drive_reg <= '0;
		end
		else
		begin
			brake_source_select_reg <= brake_source_select_next;
			brake_edge_level_select_reg <= brake_edge_level_select_next;
			light_duty_rating_reg <= light_duty_rating_next;
			brake_freq_threshold_reg <= brake_freq_threshold_next;
			brake_freerun_delay_reg <= brake_freerun_delay_next;
			brake_current_level_reg <= brake_current_level_next;
			brake_active_time_reg <= brake_active_time_next;
			term_assign_reg <= term_assign_next;
			dat_reg <= dat_next;
			ack_reg <= ack_next;
			state_reg <= state_next;
			pre_reg <= pre_next;
			time_reg <= time_next;
			stop_latch_reg <= stop_latch_next;
			freq_latch_reg <= freq_latch_next;
			trig_prev_reg <= trig_prev_next;
			drive_reg <= drive_next;
		end
	end

	assign wb_dat_o = dat_reg;
	assign wb_ack_o = ack_reg;
	assign drive_out = drive_reg;

endmodule

// ===== testbench/dcb_chk.sv
// Purpose: Port checks for the DC braking control block
// Assumes: Bound to every dcb_brake_ctrl instance
// Notes: Bus timing follows the one-cycle ack of the slave
`timescale 1ns/1ps
module dcb_chk
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	// Drive
	input wire dcb_pkg::dcb_drive_t drive_out
);
	import dcb_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_brake_start;
		$rose(drive_out.brake_on);
	endsequence
	a_rst_quiet: assert property (disable iff (1'b0) !resetn |=> drive_out == 9'h000 && !wb_ack_o)
		else $error("outputs not quiet after reset");
	a_ack_next: assert property (s_req |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
		else $error("read data outside ack");
	a_shut_first: assert property (s_brake_start |-> $past(drive_out.shutoff))
		else $error("braking without prior shutoff");
	a_brake_shut: assert property (drive_out.brake_on |-> drive_out.shutoff)
		else $error("braking with output enabled");
	a_idle_cur: assert property (!drive_out.brake_on |-> drive_out.current_pct == 7'h00)
		else $error("current while not braking");
	a_cur_cap: assert property (drive_out.brake_on |-> drive_out.current_pct <= 7'h64)
		else $error("current above rated");
endmodule
bind dcb_brake_ctrl dcb_chk u_chk (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .drive_out(drive_out));

// ===== testbench/dcb_motor.sv
// Purpose: Motor speed seen by the braking block
// Assumes: Speed in 0.01 Hz counts
// Notes: Steep ramps keep scenarios short; shutoff coasts to zero
`timescale 1ns/1ps
module dcb_motor
(
	// Clock and drive
	input wire logic ref_clk,
	input wire logic run_cmd,
	input wire logic [15:0] freq_cmd,
	input wire dcb_pkg::dcb_drive_t drive_out,
	// Speed
	output logic [15:0] out_freq
);
	import dcb_pkg::*;
	logic [15:0] tgt;
	initial out_freq = 16'h0000;
	assign tgt = (run_cmd && !drive_out.shutoff) ? freq_cmd : 16'h0000;
	always @(posedge ref_clk)
	begin
		if (out_freq > tgt + 16'h0010)
			out_freq <= out_freq - 16'h0010;
		else if (out_freq + 16'h0010 < tgt)
			out_freq <= out_freq + 16'h0010;
		else
			out_freq <= tgt;
	end
endmodule

// ===== testbench/dc_braking_stop_control_bench.sv
// Purpose: Register and braking scenarios for dcb_brake_ctrl
// Assumes: Tick shortened to 4 cycles
// Notes: Threshold 5.00 Hz throughout the braking scenarios
`timescale 1ns/1ps
`include "dcb_cfg.svh"
module dc_braking_stop_control_bench;
	import dcb_pkg::*;
	localparam int TK = 4;
	logic ref_clk, resetn, cyc, stb, we, ack, run;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dati, dato, rv;
	logic [15:0] fcmd, ofreq;
	logic [6:0] term;
	dcb_drive_t drv;
	int fail_count = 0;
	int checked = 0;
	int n;
	dcb_brake_ctrl #(.TICK_CYCLES(TK)) DUT (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dati),
		.wb_dat_o(dato), .wb_ack_o(ack), .motor_in({run, fcmd, ofreq, term}), .drive_out(drv));
	dcb_motor M (.ref_clk(ref_clk), .run_cmd(run), .freq_cmd(fcmd), .drive_out(drv),
		.out_freq(ofreq));
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic close_out;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s = 4'hF);
		int t;
		t = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= s;
		adr <= a;
		dati <= d;
		do
		begin
			@(posedge ref_clk);
			t++;
		end
		while (ack !== 1'b1 && t < 20);
		rv = dato;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk("ack", 1, t < 20);
		@(posedge ref_clk);
	endtask
	// Waits a bounded number of cycles for the braking flag; n holds the wait
	task automatic wbrk(logic v, int lim);
		n = 0;
		while (drv.brake_on !== v && n < lim)
		begin
			@(posedge ref_clk);
			n++;
		end
		chk("brake_on", v, drv.brake_on);
	endtask
	initial
	begin
		resetn = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dati = 32'h00000000;
		run = 1'b0;
		fcmd = 16'h0000;
		term = 7'h00;
		repeat (4) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		bus(1'b1, `DCB_ADR_THRESH, 32'h0000FFFF);
		bus(1'b0, `DCB_ADR_THRESH, 32'h0);
		chk("thresh", 32'h00001770, rv);
		bus(1'b1, `DCB_ADR_LEVEL, 32'h0000007F);
		bus(1'b0, `DCB_ADR_LEVEL, 32'h0);
		chk("level", 32'h00000064, rv);
		bus(1'b0, 8'h1C, 32'h0);
		chk("unmapped", 32'h00000000, rv);
		// Low byte lane off: the write is acked but dropped
		bus(1'b1, `DCB_ADR_DELAY, 32'h00000001, 4'h0);
		bus(1'b0, `DCB_ADR_DELAY, 32'h0);
		chk("sel_masked", 32'h00000000, rv);
		bus(1'b1, `DCB_ADR_THRESH, 32'h000001F4);
		bus(1'b1, `DCB_ADR_ACTIVE, 32'h00000002);
		bus(1'b1, `DCB_ADR_TERM, 32'h00000001);
		chk("brake_on", 0, drv.brake_on);
		term <= 7'h01;
		wbrk(1'b1, 20);
		chk("current", 32'h64, drv.current_pct);
		wbrk(1'b0, 20);
		chk("active_time", 1, n >= 2 * TK && n <= 2 * TK + 1);
		chk("shutoff", 0, drv.shutoff);
		term <= 7'h00;
		bus(1'b1, `DCB_ADR_CTRL, 32'h0000000C);
		term <= 7'h01;
		wbrk(1'b1, 20);
		chk("current", 32'h46, drv.current_pct);
		repeat (20) @(posedge ref_clk);
		chk("brake_on", 1, drv.brake_on);
		term <= 7'h00;
		wbrk(1'b0, 5);
		run <= 1'b1;
		fcmd <= 16'h0400;
		repeat (80) @(posedge ref_clk);
		bus(1'b1, `DCB_ADR_CTRL, 32'h00000006);
		term <= 7'h01;
		repeat (20) @(posedge ref_clk);
		chk("brake_on", 0, drv.brake_on);
		term <= 7'h00;
		fcmd <= 16'h0100;
		wbrk(1'b1, 100);
		fcmd <= 16'h02BB;
		repeat (10) @(posedge ref_clk);
		chk("brake_on", 1, drv.brake_on);
		fcmd <= 16'h02BC;
		wbrk(1'b0, 20);
		fcmd <= 16'h0400;
		bus(1'b1, `DCB_ADR_CTRL, 32'h00000005);
		repeat (80) @(posedge ref_clk);
		run <= 1'b0;
		wbrk(1'b1, 100);
		repeat (30) @(posedge ref_clk);
		chk("brake_on", 1, drv.brake_on);
		run <= 1'b1;
		wbrk(1'b0, 5);
		// One tick of free run before edge braking from the terminal
		bus(1'b1, `DCB_ADR_DELAY, 32'h00000001);
		bus(1'b1, `DCB_ADR_CTRL, 32'h00000000);
		term <= 7'h01;
		repeat (2) @(posedge ref_clk);
		chk("freerun", 32'h2, {drv.shutoff, drv.brake_on});
		wbrk(1'b1, 20);
		chk("delay", 1, n >= TK && n <= TK + 1);
		bus(1'b0, `DCB_ADR_STATUS, 32'h0);
		chk("status", 32'h00000027, rv);
		wbrk(1'b0, 20);
		term <= 7'h00;
		close_out();
	end
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		fail_count++;
		close_out();
	end
endmodule
